// ===== inc/rtca_pkg.sv
// Package for the calendar alarm, countdown, temperature and user data pages.
// Assumes a 32-bit AXI4-Lite register bus and register indices scaled by four.
package rtca_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int           IDX_W               = 7;
  localparam logic [6:0]   IDX_WEEKDAY_ALARM   = 7'h14;
  localparam logic [6:0]   IDX_MONTH_ALARM     = 7'h15;
  localparam logic [6:0]   IDX_YEAR_ALARM      = 7'h16;
  localparam logic [6:0]   IDX_COUNTDOWN_LOW   = 7'h18;
  localparam logic [6:0]   IDX_COUNTDOWN_HIGH  = 7'h19;
  localparam logic [6:0]   IDX_TEMPERATURE     = 7'h20;
  localparam logic [6:0]   IDX_USER_NV_0       = 7'h28;
  localparam logic [6:0]   IDX_USER_NV_1       = 7'h29;
  localparam logic [6:0]   IDX_NV_SETTINGS     = 7'h30;
  localparam logic [6:0]   IDX_CAL_OFFSET      = 7'h31;
  localparam logic [6:0]   IDX_CAL_COEF        = 7'h32;
  localparam logic [6:0]   IDX_CAL_TURNOVER    = 7'h33;
  localparam logic [6:0]   IDX_ALARM_CTRL      = 7'h40;

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  localparam int           ENABLE_BIT          = 7;
  localparam int           WEEKDAY_W           = 3;
  localparam int           MONTH_W             = 5;
  localparam int           YEAR_W              = 7;
  localparam int           THERM_ENABLE_BIT    = 1;
  localparam int           THERM_PERIOD_BIT    = 0;
  localparam int           CLK_SEL_LSB         = 2;
  localparam int           CHARGE_LSB          = 4;
  localparam int           CTRL_IRQ_EN_BIT     = 0;
  localparam int           CTRL_FLAG_BIT       = 1;
  localparam int           TURNOVER_W          = 6;

  // ----------------------------------------------------------------
  // Reset values and bus answers
  // ----------------------------------------------------------------
  localparam logic [7:0]   RST_BYTE            = 8'h00;
  localparam logic [7:0]   TEMP_ZERO_C         = 8'h3c;
  localparam logic [1:0]   RESP_OKAY           = 2'h0;
  localparam logic [1:0]   RESP_SLVERR         = 2'h2;

  // Alarm register: enable and match target
  typedef struct packed {
    logic       en;
    logic [6:0] target;
  } rtca_alarm_t;

  // Current calendar date from the watch logic
  typedef struct packed {
    logic [2:0] weekday;
    logic [4:0] month;
    logic [6:0] year;
  } rtca_date_t;

  // Non-volatile settings decoded for the rest of the chip
  typedef struct packed {
    logic [3:0] charge_sel;
    logic [1:0] clock_output_pin_sel;
    logic       therm_enable;
    logic       therm_slow_scan;
  } rtca_nv_cfg_t;

endpackage

// ===== src/rtca_regs.sv
// Alarm, countdown reload, temperature and user data registers behind AXI4-Lite.
// Assumes the calendar date and temperature samples come from logic on ref_clk.
`timescale 1ns/10ps
`default_nettype none

module rtca_regs
  import rtca_pkg::*;
#(
  parameter int         ADDR_W        = 9,
  parameter logic [7:0] CAL_OFFSET_RST = 8'h00,
  parameter logic [7:0] CAL_COEF_RST  = 8'h00,
  parameter logic [7:0] CAL_TURN_RST  = 8'h00
) (
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Calendar and thermometer
  input  wire rtca_date_t        cur_date,
  input  wire logic              temp_sample_valid,
  input  wire logic [7:0]        temp_sample,
  // Outputs to the rest of the clock
  output logic [15:0]            timer_reload,
  output logic [7:0]             temperature,
  output rtca_nv_cfg_t           nv_cfg,
  output logic [7:0]             cal_offset,
  output logic [7:0]             cal_coef,
  output logic [7:0]             cal_turnover,
  output logic                   alarm_flag,
  output logic                   alarm_irq
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  rtca_alarm_t       weekday_alarm;
  rtca_alarm_t       month_alarm;
  rtca_alarm_t       year_alarm;
  logic [7:0]        user_nv_byte_0;
  logic [7:0]        user_nv_byte_1;
  logic [7:0]        nv_settings;
  logic              alarm_irq_enable;
  logic              temp_pending;
  logic [7:0]        temp_pending_val;

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  logic              aw_held;
  logic              w_held;
  logic [IDX_W-1:0]  wr_idx;
  logic [7:0]        wr_byte;
  logic              wr_lane0;
  logic              wr_fire;
  logic              wr_hit;
  logic              access_busy;

  // Address and data are taken in either order, one write at a time
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_held <= 1'b0;
      wr_idx  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      wr_idx  <= s_axi_awaddr[IDX_W+1:2];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      w_held   <= 1'b0;
      wr_byte  <= RST_BYTE;
      wr_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held   <= 1'b1;
      wr_byte  <= s_axi_wdata[7:0];
      wr_lane0 <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // Address decode for writes
  always_comb begin
    if (wr_idx == IDX_WEEKDAY_ALARM) begin
      wr_hit = 1'b1;
    end else if (wr_idx == IDX_MONTH_ALARM || wr_idx == IDX_YEAR_ALARM) begin
      wr_hit = 1'b1;
    end else if (wr_idx == IDX_COUNTDOWN_LOW || wr_idx == IDX_COUNTDOWN_HIGH) begin
      wr_hit = 1'b1;
    end else if (wr_idx == IDX_TEMPERATURE) begin
      wr_hit = 1'b1;
    end else if (wr_idx == IDX_USER_NV_0 || wr_idx == IDX_USER_NV_1) begin
      wr_hit = 1'b1;
    end else if (wr_idx >= IDX_NV_SETTINGS && wr_idx <= IDX_CAL_TURNOVER) begin
      wr_hit = 1'b1;
    end else if (wr_idx == IDX_ALARM_CTRL) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Write response stays up until the master takes it
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte strobe for the single data lane in use
  logic wr_en;
  assign wr_en = wr_fire && wr_lane0;

  // ----------------------------------------------------------------
  // Alarm registers
  // ----------------------------------------------------------------
  // Only the documented fields are stored, so unused bits cannot stick
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      weekday_alarm <= '0;
      month_alarm   <= '0;
      year_alarm    <= '0;
    end else if (wr_en) begin
      if (wr_idx == IDX_WEEKDAY_ALARM) begin
        weekday_alarm.en     <= wr_byte[ENABLE_BIT];
        weekday_alarm.target <= {4'h0, wr_byte[WEEKDAY_W-1:0]};
      end else if (wr_idx == IDX_MONTH_ALARM) begin
        month_alarm.en       <= wr_byte[ENABLE_BIT];
        month_alarm.target   <= {2'h0, wr_byte[MONTH_W-1:0]};
      end else if (wr_idx == IDX_YEAR_ALARM) begin
        year_alarm           <= wr_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Countdown reload and user bytes
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timer_reload   <= '0;
      user_nv_byte_0 <= RST_BYTE;
      user_nv_byte_1 <= RST_BYTE;
    end else if (wr_en) begin
      if (wr_idx == IDX_COUNTDOWN_LOW) begin
        timer_reload[7:0]  <= wr_byte;
      end else if (wr_idx == IDX_COUNTDOWN_HIGH) begin
        timer_reload[15:8] <= wr_byte;
      end else if (wr_idx == IDX_USER_NV_0) begin
        user_nv_byte_0     <= wr_byte;
      end else if (wr_idx == IDX_USER_NV_1) begin
        user_nv_byte_1     <= wr_byte;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control page: settings and crystal calibration
  // ----------------------------------------------------------------
  // Calibration values reset to per-unit parameters; software rarely changes them
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      nv_settings  <= RST_BYTE;
      cal_offset   <= CAL_OFFSET_RST;
      cal_coef     <= CAL_COEF_RST;
      cal_turnover <= CAL_TURN_RST;
    end else if (wr_en) begin
      if (wr_idx == IDX_NV_SETTINGS) begin
        nv_settings  <= wr_byte;
      end else if (wr_idx == IDX_CAL_OFFSET) begin
        cal_offset   <= wr_byte;
      end else if (wr_idx == IDX_CAL_COEF) begin
        cal_coef     <= wr_byte;
      end else if (wr_idx == IDX_CAL_TURNOVER) begin
        cal_turnover <= {2'h0, wr_byte[TURNOVER_W-1:0]};
      end
    end
  end

  // Settings fields fanned out to charger, clock output and thermometer
  assign nv_cfg.charge_sel           = nv_settings[CHARGE_LSB+3:CHARGE_LSB];
  assign nv_cfg.clock_output_pin_sel = nv_settings[CLK_SEL_LSB+1:CLK_SEL_LSB];
  assign nv_cfg.therm_enable         = nv_settings[THERM_ENABLE_BIT];
  assign nv_cfg.therm_slow_scan      = nv_settings[THERM_PERIOD_BIT];

  // ----------------------------------------------------------------
  // Temperature result with access freeze
  // ----------------------------------------------------------------
  // Bus activity except s_axi_wvalid before its handshake freezes the value; samples wait and land afterwards
  assign access_busy = aw_held || w_held || s_axi_bvalid || s_axi_awvalid
                       || s_axi_arvalid || s_axi_rvalid;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      temperature      <= TEMP_ZERO_C;
      temp_pending     <= 1'b0;
      temp_pending_val <= RST_BYTE;
    end else if (wr_en && wr_idx == IDX_TEMPERATURE && !nv_cfg.therm_enable) begin
      temperature  <= wr_byte;
      temp_pending <= 1'b0;
    end else if (access_busy) begin
      if (temp_sample_valid && nv_cfg.therm_enable) begin
        temp_pending     <= 1'b1;
        temp_pending_val <= temp_sample;
      end
    end else if (temp_sample_valid && nv_cfg.therm_enable) begin
      temperature  <= temp_sample;
      temp_pending <= 1'b0;
    end else if (temp_pending) begin
      temperature  <= temp_pending_val;
      temp_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Alarm compare and flag
  // ----------------------------------------------------------------
  logic alarm_match;
  logic alarm_match_d;
  logic any_enabled;

  // Disabled fields compare as true; no enabled field means no alarm
  assign any_enabled = weekday_alarm.en || month_alarm.en || year_alarm.en;
  assign alarm_match = any_enabled
      && (!weekday_alarm.en || weekday_alarm.target[WEEKDAY_W-1:0] == cur_date.weekday)
      && (!month_alarm.en || month_alarm.target[MONTH_W-1:0] == cur_date.month)
      && (!year_alarm.en || year_alarm.target == cur_date.year);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_match_d <= 1'b0;
    end else begin
      alarm_match_d <= alarm_match;
    end
  end

  // Flag set on the first cycle of a match while the interrupt is enabled; set beats a clearing write
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_flag <= 1'b0;
    end else if (alarm_match && !alarm_match_d && alarm_irq_enable) begin
      alarm_flag <= 1'b1;
    end else if (wr_en && wr_idx == IDX_ALARM_CTRL && !wr_byte[CTRL_FLAG_BIT]) begin
      alarm_flag <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      alarm_irq_enable <= 1'b0;
    end else if (wr_en && wr_idx == IDX_ALARM_CTRL) begin
      alarm_irq_enable <= wr_byte[CTRL_IRQ_EN_BIT];
    end
  end

  assign alarm_irq = alarm_flag && alarm_irq_enable;

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] rd_idx;
  logic [7:0]       rd_byte;
  logic             rd_hit;
  logic [IDX_W-1:0] rd_idx_q;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_idx        = s_axi_araddr[IDX_W+1:2];

  // Read decode; upper 24 bits always read zero
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = RST_BYTE;
    if (rd_idx == IDX_WEEKDAY_ALARM) begin
      rd_byte = weekday_alarm;
    end else if (rd_idx == IDX_MONTH_ALARM) begin
      rd_byte = month_alarm;
    end else if (rd_idx == IDX_YEAR_ALARM) begin
      rd_byte = year_alarm;
    end else if (rd_idx == IDX_COUNTDOWN_LOW) begin
      rd_byte = timer_reload[7:0];
    end else if (rd_idx == IDX_COUNTDOWN_HIGH) begin
      rd_byte = timer_reload[15:8];
    end else if (rd_idx == IDX_TEMPERATURE) begin
      rd_byte = temperature;
    end else if (rd_idx == IDX_USER_NV_0) begin
      rd_byte = user_nv_byte_0;
    end else if (rd_idx == IDX_USER_NV_1) begin
      rd_byte = user_nv_byte_1;
    end else if (rd_idx == IDX_NV_SETTINGS) begin
      rd_byte = nv_settings;
    end else if (rd_idx == IDX_CAL_OFFSET) begin
      rd_byte = cal_offset;
    end else if (rd_idx == IDX_CAL_COEF) begin
      rd_byte = cal_coef;
    end else if (rd_idx == IDX_CAL_TURNOVER) begin
      rd_byte = cal_turnover;
    end else if (rd_idx == IDX_ALARM_CTRL) begin
      rd_byte = {6'h00, alarm_flag, alarm_irq_enable};
    end else begin
      rd_hit  = 1'b0;
    end
  end

  // Data captured at the address handshake, answer one cycle later
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
      rd_idx_q     <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h000000, rd_byte};
      s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rd_idx_q     <= rd_idx;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  AST_WDAY_UNUSED_ZERO: assert property (
    s_axi_rvalid && rd_idx_q == IDX_WEEKDAY_ALARM |-> s_axi_rdata[6:3] == 4'h0)
    else $error("Weekday alarm unused bits read nonzero");

  AST_MONTH_UNUSED_ZERO: assert property (
    s_axi_rvalid && rd_idx_q == IDX_MONTH_ALARM |-> s_axi_rdata[6:5] == 2'h0)
    else $error("Month alarm unused bits read nonzero");

  AST_WDAY_ENABLE_WRITE: assert property (
    wr_en && wr_idx == IDX_WEEKDAY_ALARM |=> weekday_alarm.en == $past(wr_byte[7]))
    else $error("Weekday enable not taken from bit 7");

  AST_YEAR_WRITE: assert property (
    wr_en && wr_idx == IDX_YEAR_ALARM |=> year_alarm == $past(wr_byte))
    else $error("Year alarm not stored");

  AST_TIMER_LOW: assert property (
    wr_en && wr_idx == IDX_COUNTDOWN_LOW
      |=> timer_reload[7:0] == $past(wr_byte) && $stable(timer_reload[15:8]))
    else $error("Timer low byte write wrong");

  AST_TEMP_FROZEN: assert property (
    access_busy && !(wr_en && wr_idx == IDX_TEMPERATURE) |=> $stable(temperature))
    else $error("Temperature changed during access");

  AST_TEMP_HOST_WRITE: assert property (
    wr_en && wr_idx == IDX_TEMPERATURE && !nv_cfg.therm_enable
      |=> temperature == $past(wr_byte))
    else $error("Host temperature write lost");

  AST_TEMP_HOST_BLOCKED: assert property (
    wr_en && wr_idx == IDX_TEMPERATURE && nv_cfg.therm_enable |=> $stable(temperature))
    else $error("Temperature written with thermometer on");

  AST_ALARM_SET: assert property (
    $rose(alarm_match) && alarm_irq_enable |=> alarm_flag ##0 alarm_irq)
    else $error("Alarm match did not raise flag");

  AST_ALARM_EXCLUDE: assert property (
    alarm_match |-> (!year_alarm.en || year_alarm.target == cur_date.year)
                    && (weekday_alarm.en || month_alarm.en || year_alarm.en))
    else $error("Alarm matched against excluded field");

  AST_USER_BYTE: assert property (
    wr_en && wr_idx == IDX_USER_NV_1 |=> user_nv_byte_1 == $past(wr_byte))
    else $error("User byte write lost");

  AST_SETTINGS_MAP: assert property (
    wr_en && wr_idx == IDX_NV_SETTINGS
      |=> nv_cfg.therm_enable == $past(wr_byte[1]) && nv_cfg.charge_sel == $past(wr_byte[7:4]))
    else $error("Settings fields misplaced");

  COV_ALARM: cover property ($rose(alarm_flag));
  COV_TEMP_WRITE: cover property (wr_en && wr_idx == IDX_TEMPERATURE && !nv_cfg.therm_enable);
  COV_FROZEN_SAMPLE: cover property (access_busy && temp_sample_valid ##[1:20] !temp_pending);
  COV_BAD_ADDR: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);

endmodule

`default_nettype wire

// ===== test/rtca_host.sv
// AXI4-Lite host model that reaches the register block through two tasks.
// Assumes ref_clk is shared with the block and callers start on a clock edge.
`timescale 1ns/10ps
`default_nettype none
module rtca_host (
  input  wire logic        ref_clk,
  output var  logic [8:0]  s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  output var  logic [8:0]  s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready,
  output var  logic        hang
);
  // Idle bus at time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready, hang} = '0;
  end
  // Write; a response code of 3 never comes from the block, so it marks a hang
  task automatic wr(input logic [6:0] idx, input logic [7:0] d, output logic [1:0] resp);
    resp = 2'h3;
    @(posedge ref_clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (resp === 2'h3) hang <= 1'b1;
  endtask
  // Read; address held until taken, data taken at the rvalid edge
  task automatic rd(input logic [6:0] idx, output logic [31:0] d, output logic [1:0] resp);
    resp = 2'h3;
    d = '0;
    @(posedge ref_clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (resp === 2'h3) hang <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ===== test/rtca_regs_tb.sv
// Self-checking bench for the alarm, countdown, temperature and user pages.
// Assumes the host model drives the register bus; date and samples come from here.
`timescale 1ns/10ps
`default_nettype none
module rtca_regs_tb;
  import rtca_pkg::*;
  logic ref_clk, nrst, temp_sample_valid, hang;
  logic [7:0]  temp_sample, temperature, cal_offset, cal_coef, cal_turnover;
  logic [8:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] timer_reload;
  logic        alarm_flag, alarm_irq;
  rtca_date_t   cur_date;
  rtca_nv_cfg_t nv_cfg;
  int failures = 0;
  int checked = 0;
  // Alarm, timer, user and calibration bytes: written value and expected read-back
  logic [6:0] tidx [10] = '{IDX_WEEKDAY_ALARM, IDX_MONTH_ALARM, IDX_YEAR_ALARM,
    IDX_COUNTDOWN_LOW, IDX_COUNTDOWN_HIGH, IDX_USER_NV_0, IDX_USER_NV_1,
    IDX_CAL_OFFSET, IDX_CAL_COEF, IDX_CAL_TURNOVER};
  logic [7:0] twd [10] = '{8'hff, 8'hff, 8'hff, 8'h34, 8'h12, 8'ha5, 8'h5a,
    8'h81, 8'h7e, 8'hff};
  logic [7:0] texp [10] = '{8'h87, 8'h9f, 8'hff, 8'h34, 8'h12, 8'ha5, 8'h5a,
    8'h81, 8'h7e, 8'h3f};

  rtca_regs dut_u (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cur_date, .temp_sample_valid, .temp_sample, .timer_reload,
    .temperature, .nv_cfg, .cal_offset, .cal_coef, .cal_turnover, .alarm_flag, .alarm_irq);
  rtca_host host_u (.ref_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .hang);

  // Free-running 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // A stuck handshake ends the run
  always @(posedge ref_clk) if (hang === 1'b1) begin
    failures++;
    summarize();
  end

  task automatic summarize;
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [6:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    host_u.rd(idx, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic wrc(input logic [6:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [1:0] r;
    host_u.wr(idx, d, r);
    chk({30'h0, r}, {30'h0, er});
  endtask

  // Main sequence
  initial begin
    nrst = 1'b0;
    temp_sample_valid = 1'b0;
    temp_sample = 8'h00;
    cur_date = '{weekday: 3'h3, month: 5'h05, year: 7'h25};
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 10; i++) rdc(tidx[i], 8'h00, RESP_OKAY);
    rdc(IDX_TEMPERATURE, TEMP_ZERO_C, RESP_OKAY);
    for (int i = 0; i < 10; i++) begin
      wrc(tidx[i], twd[i], RESP_OKAY);
      rdc(tidx[i], texp[i], RESP_OKAY);
    end
    chk({16'h0, timer_reload}, 32'h1234);
    chk({8'h0, cal_offset, cal_coef, cal_turnover}, 32'h00817e3f);
    wrc(7'h17, 8'h55, RESP_SLVERR);
    rdc(7'h17, 8'h00, RESP_SLVERR);
    wrc(IDX_NV_SETTINGS, 8'hb6, RESP_OKAY);
    chk({24'h0, nv_cfg}, 32'hb6);
    wrc(IDX_TEMPERATURE, 8'h11, RESP_OKAY);
    rdc(IDX_TEMPERATURE, TEMP_ZERO_C, RESP_OKAY);
    temp_sample <= 8'hfa;
    temp_sample_valid <= 1'b1;
    @(posedge ref_clk);
    temp_sample_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rdc(IDX_TEMPERATURE, 8'hfa, RESP_OKAY);
    // A sample that lands while a read is under way must wait for the bus to go idle
    temp_sample <= 8'h50;
    fork
      rdc(IDX_TEMPERATURE, 8'hfa, RESP_OKAY);
      begin
        @(posedge ref_clk);
        temp_sample_valid <= 1'b1;
        @(posedge ref_clk);
        temp_sample_valid <= 1'b0;
      end
    join
    rdc(IDX_TEMPERATURE, 8'h50, RESP_OKAY);
    wrc(IDX_NV_SETTINGS, 8'h00, RESP_OKAY);
    wrc(IDX_TEMPERATURE, 8'h11, RESP_OKAY);
    rdc(IDX_TEMPERATURE, 8'h11, RESP_OKAY);
    chk({24'h0, temperature}, 32'h11);
    // Year stays enabled on a wrong target, so no match until it is fixed
    wrc(IDX_ALARM_CTRL, 8'h01, RESP_OKAY);
    wrc(IDX_WEEKDAY_ALARM, 8'h83, RESP_OKAY);
    wrc(IDX_MONTH_ALARM, 8'h15, RESP_OKAY);
    chk({31'h0, alarm_flag}, 32'h0);
    wrc(IDX_YEAR_ALARM, 8'ha5, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk({30'h0, alarm_irq, alarm_flag}, 32'h3);
    rdc(IDX_ALARM_CTRL, 8'h03, RESP_OKAY);
    wrc(IDX_ALARM_CTRL, 8'h01, RESP_OKAY);
    rdc(IDX_ALARM_CTRL, 8'h01, RESP_OKAY);
    chk({30'h0, alarm_irq, alarm_flag}, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
